//--- pmw_consts.svh
// Overview of operation
// RULE1 - State field: full, frame wake, energy wake
// RULE2 - Byte check write wakes device from low power
// RULE3 - Host writes only byte check while not ready
// RULE4 - Writes ignored until a first read
// RULE5 - Power control stays readable in low power
// RULE6 - PHY reset request holds reset 100us, self-clears
// RULE7 - Writes to set PHY request bit ignored
// RULE8 - Remote wake event drives output and interrupt
// RULE9 - Energy event drives output and interrupt
// RULE10 - Drive type clear: open-drain, active low
// RULE11 - Cause field encodes none, energy, frame, multiple
// RULE12 - Write one clears cause, only when ready
// RULE13 - Cause clears only once its source is quiet
// RULE14 - Pulse select: 50ms pulse, else static level
// RULE15 - Output drops on cause clear or enable clear
// RULE16 - Polarity bit picks level, ignored in open-drain
// RULE17 - Output enable gates pin, not interrupt
// RULE18 - Ready bit set after settling, always readable
// RULE19 - Second different event records multiple code
`ifndef PMW_CONSTS_SVH
`define PMW_CONSTS_SVH
`define PMW_OFF_PWR 8'h84
`define PMW_OFF_BYTE 8'h64
`define PMW_OFF_STS 8'h50
`define PMW_OFF_MASK 8'h54
`define PMW_BYTE_VAL 32'h0123_4567
`define PMW_B_READY 0
`define PMW_B_OUT_EN 1
`define PMW_B_POL 2
`define PMW_B_PULSE 3
`define PMW_B_CAUSE 5:4
`define PMW_B_DRV 6
`define PMW_B_ENERGY_WAKE_ENABLE 8
`define PMW_B_REMOTE_WAKE_ENABLE 9
`define PMW_B_PHY 10
`define PMW_B_PS 13:12
`define PMW_CAUSE_NONE 2'h0
`define PMW_CAUSE_ENERGY 2'h1
`define PMW_CAUSE_FRAME 2'h2
`define PMW_CAUSE_MULTI 2'h3
`define PMW_STS_WAKE 0
`define PMW_STS_PHY 1
`define PMW_RESP_OKAY 2'h0
`define PMW_RESP_SLVERR 2'h2
`define PMW_CLK_NS 5
`define PMW_PHY_RESET_REQUEST_US 100
`define PMW_PULSE_MS 50
`define PMW_SETTLE_CYC 5'h10
`define PMW_TMR_W 24
`endif

//--- pmw_pkg.sv
`include "pmw_consts.svh"
package pmw_pkg;
  typedef enum logic [1:0] {
    PMW_FULL = 2'b00,
    PMW_FRAME = 2'b01,
    PMW_ENERGY = 2'b10
  } pmw_pstate_t;
  typedef struct packed {
    logic aw_vld;
    logic [7:0] aw_addr;
    logic w_vld;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic b_vld;
    logic [1:0] b_resp;
    logic r_vld;
    logic [31:0] r_data;
    logic [1:0] r_resp;
    pmw_pstate_t pstate;
    logic ready;
    logic [4:0] settle;
    logic read_seen;
    logic remote_wake_enable;
    logic energy_wake_enable;
    logic drv_type;
    logic [1:0] cause;
    logic pulse_sel;
    logic pol;
    logic out_en;
    logic phy_reset_request;
    logic [1:0] sts;
    logic [1:0] mask;
    logic irq;
  } pmw_state_t;
  typedef struct packed {
    logic [`PMW_TMR_W-1:0] cnt;
  } pmw_tmr_t;
  typedef struct packed {
    logic pin;
    logic oe;
  } pmw_pad_t;
endpackage : pmw_pkg

//--- pmw_timer.sv
`timescale 1ns/1ps
`include "pmw_consts.svh"
module pmw_timer import pmw_pkg::*; #(
  parameter int unsigned CYC = 1
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  output logic busy_o
);
  pmw_tmr_t s;
  pmw_tmr_t n;

  // A restart reloads the full span, so repeated starts stretch it
  always_comb begin
    n = s;
    if (start_i) begin
      n.cnt = `PMW_TMR_W'(CYC);
    end else if (s.cnt != '0) begin
      n.cnt = s.cnt - 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign busy_o = (s.cnt != '0);
endmodule : pmw_timer

//--- pmw_wake_pad.sv
`timescale 1ns/1ps
`include "pmw_consts.svh"
module pmw_wake_pad import pmw_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic active_i,
  input wire logic push_pull_i,
  input wire logic active_high_i,
  output logic pin_o,
  output logic pin_oe_o
);
  pmw_pad_t s;
  pmw_pad_t n;

  // Open-drain only sinks, so polarity cannot apply there
  always_comb begin
    n = s;
    if (push_pull_i) begin
      n.oe = 1'b1;
      n.pin = active_high_i ? active_i : !active_i; // see RULE16
    end else begin
      n.oe = active_i; // see RULE10
      n.pin = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  assign pin_o = s.pin;
  assign pin_oe_o = s.oe;
endmodule : pmw_wake_pad

//--- pmw_power_ctrl.sv
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pmw_consts.svh"
module pmw_power_ctrl import pmw_pkg::*; #(
  parameter int unsigned PHY_RESET_REQUEST_CYC = (`PMW_PHY_RESET_REQUEST_US * 1000 + `PMW_CLK_NS - 1) / `PMW_CLK_NS,
  parameter int unsigned PULSE_CYC = `PMW_PULSE_MS * 1000000 / `PMW_CLK_NS
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic s_axi_awvalid_i,
  output logic s_axi_awready_o,
  input wire logic [7:0] s_axi_awaddr_i,
  input wire logic s_axi_wvalid_i,
  output logic s_axi_wready_o,
  input wire logic [31:0] s_axi_wdata_i,
  input wire logic [3:0] s_axi_wstrb_i,
  output logic s_axi_bvalid_o,
  input wire logic s_axi_bready_i,
  output logic [1:0] s_axi_bresp_o,
  input wire logic s_axi_arvalid_i,
  output logic s_axi_arready_o,
  input wire logic [7:0] s_axi_araddr_i,
  output logic s_axi_rvalid_o,
  input wire logic s_axi_rready_i,
  output logic [31:0] s_axi_rdata_o,
  output logic [1:0] s_axi_rresp_o,
  input wire logic remote_wake_event_i,
  input wire logic energy_event_i,
  output logic [1:0] power_state_o,
  output logic device_ready_o,
  output logic phy_reset_o,
  output logic wake_irq_o,
  output logic wake_pin_o,
  output logic wake_pin_oe_o
);
  pmw_state_t s;
  pmw_state_t n;
  logic [31:0] pwr_rd;
  logic [31:0] wmask;
  logic [31:0] wd;
  logic [31:0] pw;
  logic wr_go;
  logic wr_ok;
  logic hit_pwr;
  logic hit_byte;
  logic hit_sts;
  logic hit_mask;
  logic ar_go;
  logic ev_fr;
  logic ev_en;
  logic pulse_start;
  logic phy_start;
  logic phy_busy;
  logic pulse_busy;
  logic wake_act;

  function automatic logic word_hit(input logic [7:0] a, input logic [7:0] off);
    return a[7:2] == off[7:2];
  endfunction : word_hit

  // Read view of the power control word
  assign pwr_rd = {18'h0, s.pstate, 1'b0, s.phy_reset_request, s.remote_wake_enable, s.energy_wake_enable, 1'b0, s.drv_type,
                   s.cause, s.pulse_sel, s.pol, s.out_en, s.ready};

  // Byte lanes of the held write
  assign wmask = {{8{s.w_strb[3]}}, {8{s.w_strb[2]}}, {8{s.w_strb[1]}}, {8{s.w_strb[0]}}};
  assign wd = s.w_data & wmask;
  assign pw = (pwr_rd & ~wmask) | wd;

  // Write address decode on the held address
  assign hit_pwr = word_hit(s.aw_addr, `PMW_OFF_PWR);
  assign hit_byte = word_hit(s.aw_addr, `PMW_OFF_BYTE);
  assign hit_sts = word_hit(s.aw_addr, `PMW_OFF_STS);
  assign hit_mask = word_hit(s.aw_addr, `PMW_OFF_MASK);
  assign wr_go = s.aw_vld && s.w_vld && !s.b_vld;
  assign ar_go = s_axi_arvalid_i && !s.r_vld;

  // Only the byte check word may be written while not ready
  assign wr_ok = s.read_seen && (s.ready || hit_byte); // see RULE3 see RULE4

  // Qualified wake events
  assign ev_fr = remote_wake_event_i && s.remote_wake_enable; // see RULE8
  assign ev_en = energy_event_i && s.energy_wake_enable; // see RULE9
  assign pulse_start = ev_fr || ev_en;

  // A set request bit blocks a second start
  assign phy_start = wr_go && wr_ok && hit_pwr && s.w_strb[1] && s.w_data[`PMW_B_PHY]
                     && !s.phy_reset_request; // see RULE7

  // Pin level follows causes whose source is still enabled
  assign wake_act = s.out_en && ((s.cause[1] && s.remote_wake_enable) || (s.cause[0] && s.energy_wake_enable))
                    && (!s.pulse_sel || pulse_busy); // see RULE14 see RULE15 see RULE17

  // Next state: bus, control fields, events
  always_comb begin
    n = s;
    if (s.b_vld && s_axi_bready_i) begin
      n.b_vld = 1'b0;
    end
    if (s.r_vld && s_axi_rready_i) begin
      n.r_vld = 1'b0;
    end
    if (s_axi_awvalid_i && s_axi_awready_o) begin
      n.aw_vld = 1'b1;
      n.aw_addr = s_axi_awaddr_i;
    end
    if (s_axi_wvalid_i && s_axi_wready_o) begin
      n.w_vld = 1'b1;
      n.w_data = s_axi_wdata_i;
      n.w_strb = s_axi_wstrb_i;
    end
    if (wr_go) begin
      n.aw_vld = 1'b0;
      n.w_vld = 1'b0;
      n.b_vld = 1'b1;
      n.b_resp = (hit_pwr || hit_byte || hit_sts || hit_mask) ? `PMW_RESP_OKAY : `PMW_RESP_SLVERR;
    end
    // Gated writes still answer OKAY, they just do nothing
    if (wr_go && wr_ok && hit_pwr) begin
      n.remote_wake_enable = pw[`PMW_B_REMOTE_WAKE_ENABLE];
      n.energy_wake_enable = pw[`PMW_B_ENERGY_WAKE_ENABLE];
      n.drv_type = pw[`PMW_B_DRV];
      n.pulse_sel = pw[`PMW_B_PULSE];
      n.pol = pw[`PMW_B_POL];
      n.out_en = pw[`PMW_B_OUT_EN];
      // Ready implies full operation here, so clears may act
      n.cause = s.cause & ~wd[`PMW_B_CAUSE]; // see RULE12
      // Reserved code and a no-op full request are ignored
      if (pw[`PMW_B_PS] == PMW_FRAME || pw[`PMW_B_PS] == PMW_ENERGY) begin // see RULE1
        n.pstate = pmw_pstate_t'(pw[`PMW_B_PS]);
        n.ready = 1'b0;
        n.settle = '0;
      end
      if (phy_start) begin
        n.phy_reset_request = 1'b1; // see RULE6
      end
    end
    if (wr_go && wr_ok && hit_mask) begin
      n.mask = (s.mask & ~wmask[1:0]) | wd[1:0];
    end
    // Reads; status clears on read, events below still win
    if (ar_go) begin
      n.r_vld = 1'b1;
      n.read_seen = 1'b1; // see RULE4
      n.r_resp = `PMW_RESP_OKAY;
      n.r_data = '0;
      if (word_hit(s_axi_araddr_i, `PMW_OFF_PWR)) begin
        n.r_data = pwr_rd; // see RULE5 see RULE18
      end else if (word_hit(s_axi_araddr_i, `PMW_OFF_BYTE)) begin
        n.r_data = `PMW_BYTE_VAL;
      end else if (word_hit(s_axi_araddr_i, `PMW_OFF_STS)) begin
        n.r_data = {30'h0, s.sts};
        n.sts = '0;
      end else if (word_hit(s_axi_araddr_i, `PMW_OFF_MASK)) begin
        n.r_data = {30'h0, s.mask};
      end else begin
        n.r_resp = `PMW_RESP_SLVERR;
      end
    end
    // An accepted byte check write in low power leaves it and re-arms the read gate
    if (wr_go && wr_ok && hit_byte && s.pstate != PMW_FULL) begin // see RULE2
      n.pstate = PMW_FULL;
      n.ready = 1'b0;
      n.settle = '0;
      n.read_seen = 1'b0; // see RULE4
    end
    // Settling after reset or wake before ready is shown
    if (!s.ready && s.pstate == PMW_FULL) begin
      if (s.settle == `PMW_SETTLE_CYC) begin
        n.ready = 1'b1; // see RULE18
      end else begin
        n.settle = s.settle + 1'b1;
      end
    end
    // Release the PHY once the hold time has run out
    if (s.phy_reset_request && !phy_busy) begin
      n.phy_reset_request = 1'b0; // see RULE6
      n.sts[`PMW_STS_PHY] = 1'b1;
    end
    // Event sets beat clears; bits OR into the multiple code
    n.cause = n.cause | {ev_fr, ev_en}; // see RULE11 see RULE13 see RULE19
    if (pulse_start) begin
      n.sts[`PMW_STS_WAKE] = 1'b1; // see RULE8 see RULE9
    end
    n.irq = |(n.sts & n.mask);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= n;
    end
  end

  // Hold of the PHY reset line
  pmw_timer #(
    .CYC(PHY_RESET_REQUEST_CYC)
  ) u_phy_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(phy_start),
    .busy_o(phy_busy)
  );

  // Pulse width of the wake pin
  pmw_timer #(
    .CYC(PULSE_CYC)
  ) u_pulse_tmr (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(pulse_start),
    .busy_o(pulse_busy)
  );

  pmw_wake_pad u_pad (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .active_i(wake_act),
    .push_pull_i(s.drv_type),
    .active_high_i(s.pol),
    .pin_o(wake_pin_o),
    .pin_oe_o(wake_pin_oe_o)
  );

  // Bus handshakes and registered outputs
  assign s_axi_awready_o = !s.aw_vld && !s.b_vld;
  assign s_axi_wready_o = !s.w_vld && !s.b_vld;
  assign s_axi_bvalid_o = s.b_vld;
  assign s_axi_bresp_o = s.b_resp;
  assign s_axi_arready_o = !s.r_vld;
  assign s_axi_rvalid_o = s.r_vld;
  assign s_axi_rdata_o = s.r_data;
  assign s_axi_rresp_o = s.r_resp;
  assign power_state_o = s.pstate;
  assign device_ready_o = s.ready;
  assign phy_reset_o = s.phy_reset_request;
  assign wake_irq_o = s.irq;

  // Helper: length of the current PHY reset hold
  int unsigned phy_hi_cnt;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      phy_hi_cnt <= 0;
    end else begin
      phy_hi_cnt <= s.phy_reset_request ? phy_hi_cnt + 1 : 0;
    end
  end

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  state_code_a: assert property (s.pstate != 2'b11) // see RULE1
    else $error("reserved power state entered");
  byte_wake_a: assert property (wr_go && wr_ok && hit_byte && s.pstate != PMW_FULL // see RULE2
    |=> s.pstate == PMW_FULL && !s.ready && !s.read_seen)
    else $error("byte check write did not wake");
  write_gate_a: assert property (wr_go && !s.read_seen && hit_pwr // see RULE4
    |=> $stable(s.remote_wake_enable) && $stable(s.mask))
    else $error("write took effect before a read");
  phy_hold_a: assert property ($fell(s.phy_reset_request) |-> $past(phy_hi_cnt) >= PHY_RESET_REQUEST_CYC) // see RULE6
    else $error("PHY reset released too early");
  phy_ignore_a: assert property (s.phy_reset_request && wr_go |=> s.phy_reset_request || !$past(phy_busy)) // see RULE7
    else $error("PHY request cleared by a write");
  irq_event_a: assert property (ev_fr && n.mask[`PMW_STS_WAKE] && !s.out_en |=> wake_irq_o) // see RULE8
    else $error("wake event missed the interrupt");
  multi_code_a: assert property (s.cause == `PMW_CAUSE_ENERGY && ev_fr |=> s.cause == `PMW_CAUSE_MULTI) // see RULE19
    else $error("second event overwrote the cause");
  od_low_a: assert property (!s.drv_type |=> !wake_pin_o) // see RULE10
    else $error("open-drain pin driven high");
  pulse_end_a: assert property (s.pulse_sel && !pulse_busy && !s.drv_type |=> !wake_pin_oe_o) // see RULE14
    else $error("pulse pin active past its span");
  cause_drop_a: assert property (s.cause == `PMW_CAUSE_NONE && !s.drv_type |=> !wake_pin_oe_o) // see RULE15
    else $error("pin active with no cause");
  // Pad registers the settings it saw, so compare against last cycle's values
  pin_gate_a: assert property (!s.out_en |=> ($past(s.drv_type) ? wake_pin_o == !$past(s.pol) // see RULE17
    : !wake_pin_oe_o))
    else $error("disabled pin shows active");
  ready_full_a: assert property (s.ready |-> s.pstate == PMW_FULL) // see RULE18
    else $error("ready shown outside full operation");

  wake_seen_c: cover property (s.pstate == PMW_ENERGY ##[1:50] s.ready);
  phy_done_c: cover property ($fell(s.phy_reset_request));
  multi_c: cover property (s.cause == `PMW_CAUSE_MULTI);
  irq_c: cover property ($rose(wake_irq_o));
endmodule : pmw_power_ctrl

//--- pmw_net_model.sv
`timescale 1ns/1ps
module pmw_net_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic fire_remote_i,
  input wire logic fire_energy_i,
  input wire logic pin_i,
  input wire logic pin_oe_i,
  output logic remote_wake_event_o,
  output logic energy_event_o,
  output logic wake_line_o
);
  // Board pull-up: an undriven shared line reads high, never the last value
  assign wake_line_o = pin_oe_i ? pin_i : 1'h1;
  // Link detector gives one-cycle event pulses, even if a request is held
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      remote_wake_event_o <= 1'h0;
      energy_event_o <= 1'h0;
    end else begin
      remote_wake_event_o <= fire_remote_i & ~remote_wake_event_o;
      energy_event_o <= fire_energy_i & ~energy_event_o;
    end
  end
endmodule : pmw_net_model

//--- test_power_mgmt_wake_ctrl.sv
`timescale 1ns/1ps
`include "pmw_consts.svh"
module test_power_mgmt_wake_ctrl;
  logic clk_i = 1'h0;
  logic rst_i = 1'h1;
  logic aw_v = 1'h0, w_v = 1'h0, b_r = 1'h0, ar_v = 1'h0, r_r = 1'h0, f_rw = 1'h0, f_ed = 1'h0;
  logic [7:0] aw_a = 8'h0, ar_a = 8'h0;
  logic [31:0] w_d = 32'h0, rdata;
  logic [1:0] bresp, rresp, resp, p_st;
  logic aw_rdy, w_rdy, b_v, ar_rdy, r_v, rw_ev, ed_ev, rdy, phy, irq, pin, pin_oe, line;
  int fails = 0, samples_checked = 0, n;

  // Short timer values keep the run brief
  pmw_power_ctrl #(.PHY_RESET_REQUEST_CYC(20), .PULSE_CYC(30)) dut (
    .clk_i(clk_i), .rst_i(rst_i),
    .s_axi_awvalid_i(aw_v), .s_axi_awready_o(aw_rdy), .s_axi_awaddr_i(aw_a),
    .s_axi_wvalid_i(w_v), .s_axi_wready_o(w_rdy), .s_axi_wdata_i(w_d), .s_axi_wstrb_i(4'hf),
    .s_axi_bvalid_o(b_v), .s_axi_bready_i(b_r), .s_axi_bresp_o(bresp),
    .s_axi_arvalid_i(ar_v), .s_axi_arready_o(ar_rdy), .s_axi_araddr_i(ar_a),
    .s_axi_rvalid_o(r_v), .s_axi_rready_i(r_r), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
    .remote_wake_event_i(rw_ev), .energy_event_i(ed_ev), .power_state_o(p_st),
    .device_ready_o(rdy), .phy_reset_o(phy), .wake_irq_o(irq),
    .wake_pin_o(pin), .wake_pin_oe_o(pin_oe)
  );

  // Link side and the pulled-up wake line
  pmw_net_model net (
    .clk_i(clk_i), .rst_i(rst_i), .fire_remote_i(f_rw), .fire_energy_i(f_ed),
    .pin_i(pin), .pin_oe_i(pin_oe), .remote_wake_event_o(rw_ev),
    .energy_event_o(ed_ev), .wake_line_o(line)
  );

  // 200 MHz clock
  initial begin
    forever #2.5 clk_i = ~clk_i;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    samples_checked++;
    if (s !== e) begin
      fails++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask : chk

  // Address and data offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    aw_a <= a;
    w_d <= d;
    aw_v <= 1'h1;
    w_v <= 1'h1;
    b_r <= 1'h1;
    do begin
      @(posedge clk_i);
      if (aw_rdy) aw_v <= 1'h0;
      if (w_rdy) w_v <= 1'h0;
    end while (!b_v);
    b_r <= 1'h0;
    resp = bresp;
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clk_i);
    ar_a <= a;
    ar_v <= 1'h1;
    r_r <= 1'h1;
    do begin
      @(posedge clk_i);
      if (ar_rdy) ar_v <= 1'h0;
    end while (!r_v);
    r_r <= 1'h0;
    resp = rresp;
    chk(rdata, e);
  endtask : rd

  // One link event, then time for cause, interrupt and pin to land
  task automatic ev(input logic remote);
    @(posedge clk_i);
    if (remote) f_rw <= 1'h1;
    else f_ed <= 1'h1;
    @(posedge clk_i);
    f_rw <= 1'h0;
    f_ed <= 1'h0;
    repeat (4) @(posedge clk_i);
  endtask : ev

  task automatic print_verdict;
    $display("checked=%0d fails=%0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  // Hang guard, well past the few hundred cycles the tests need
  initial begin
    repeat (20000) @(posedge clk_i);
    fails++;
    print_verdict();
  end

  initial begin
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (25) @(posedge clk_i);
    chk(rdy, 1);
    // A write before any read must be dropped
    wr(8'h84, 32'h346);
    chk(resp, `PMW_RESP_OKAY);
    rd(8'h84, 32'h1);
    rd(8'h64, `PMW_BYTE_VAL);
    rd(8'h10, 32'h0);
    chk(resp, `PMW_RESP_SLVERR);
    wr(8'h10, 32'h0);
    chk(resp, `PMW_RESP_SLVERR);
    // Push-pull, active high, static; both wake sources on
    wr(8'h54, 32'h1);
    wr(8'h84, 32'h346);
    rd(8'h84, 32'h347);
    rd(8'h54, 32'h1);
    ev(1'h0);
    chk(irq, 1);
    chk({pin_oe, pin}, 2'h3);
    rd(8'h84, 32'h357);
    ev(1'h1);
    rd(8'h84, 32'h377);
    rd(8'h50, 32'h1);
    rd(8'h50, 32'h0);
    repeat (3) @(posedge clk_i);
    chk(irq, 0);
    wr(8'h84, 32'h376);
    repeat (3) @(posedge clk_i);
    rd(8'h84, 32'h347);
    chk({pin_oe, pin}, 2'h2);
    wr(8'h84, 32'h342);
    repeat (3) @(posedge clk_i);
    chk(pin, 1);
    // Open-drain with the pin gated off: interrupt only
    wr(8'h84, 32'h204);
    ev(1'h1);
    chk(irq, 1);
    chk(pin_oe, 0);
    rd(8'h50, 32'h1);
    wr(8'h84, 32'h206);
    repeat (3) @(posedge clk_i);
    chk({pin_oe, line}, 2'h2);
    wr(8'h84, 32'h006);
    repeat (3) @(posedge clk_i);
    chk(line, 1);
    wr(8'h84, 32'h026);
    rd(8'h84, 32'h007);
    // Pulsed output releases while the cause stays recorded
    wr(8'h84, 32'h10a);
    ev(1'h0);
    chk({pin_oe, line}, 2'h2);
    repeat (40) @(posedge clk_i);
    chk(pin_oe, 0);
    rd(8'h84, 32'h11b);
    wr(8'h84, 32'h11a);
    rd(8'h84, 32'h10b);
    rd(8'h50, 32'h1);
    // PHY reset; a second request mid-pulse must not stretch it
    wr(8'h54, 32'h3);
    wr(8'h84, 32'h400);
    fork
      begin
        n = 0;
        repeat (60) begin
          @(posedge clk_i);
          n += phy;
        end
      end
      begin
        repeat (6) @(posedge clk_i);
        wr(8'h84, 32'h400);
      end
    join
    // First held cycle passes inside the write task, so 20 of 21 are counted
    chk(n, 20);
    chk(irq, 1);
    rd(8'h84, 32'h1);
    rd(8'h50, 32'h2);
    chk(irq, 0);
    wr(8'h54, 32'h1);
    // Each low power code, woken by the byte check write
    for (int m = 1; m < 4; m++) begin
      wr(8'h84, 32'(m << 12));
      repeat (3) @(posedge clk_i);
      if (m < 3) begin
        chk(p_st, m);
        chk(rdy, 0);
        rd(8'h84, 32'(m << 12));
        wr(8'h54, 32'h0);
        wr(8'h64, 32'h0);
        repeat (25) @(posedge clk_i);
        chk({p_st, rdy}, 3'h1);
        wr(8'h54, 32'h0);
        rd(8'h54, 32'h1);
      end else begin
        chk(p_st, 0);
        rd(8'h84, 32'h1);
      end
    end
    print_verdict();
  end
endmodule : test_power_mgmt_wake_ctrl
